// ### swwd_pkg.sv
// constants for the power-down and watchdog supervisor
package swwd_pkg;
  // ---------------------------------------------------------------
  // register indexes on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] A_IRQ_CTL = 4'h0;
  localparam logic [3:0] A_IOC_A = 4'h1;
  localparam logic [3:0] A_IOC_B = 4'h2;
  localparam logic [3:0] A_PERIPH_IRQ_ENABLE_1 = 4'h3;
  localparam logic [3:0] A_PERIPH_IRQ_ENABLE_2 = 4'h4;
  localparam logic [3:0] A_PERIPH_IRQ_FLAGS_1 = 4'h5;
  localparam logic [3:0] A_PERIPH_IRQ_FLAGS_2 = 4'h6;
  localparam logic [3:0] A_STATUS = 4'h7;
  localparam logic [3:0] A_OPTION = 4'h8;
  localparam logic [3:0] A_FUSE_LO = 4'h9;
  localparam logic [3:0] A_FUSE_HI = 4'hA;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_GATE = 6;
  localparam int B_T0IF = 2;
  localparam int B_INTE = 4;
  localparam int B_INTF = 1;
  localparam int B_IOCE = 3;
  localparam int B_IOCF = 0;
  localparam int B_ADC = 6;
  localparam int B_TMR1 = 0;
  localparam int B_TO = 4;
  localparam int B_PD = 3;
  localparam int B_INTEDG = 6;
  localparam int B_PSA = 3;
  localparam int B_WATCHDOG_CFG_ENABLE = 3;
  localparam int B_MCLRE = 5;
  // ---------------------------------------------------------------
  // reset values and implemented-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] MSK_PIN_CHANGE_ENABLE_PORT_B = 8'hF7;
  localparam logic [7:0] MSK_P1 = 8'h73;
  localparam logic [7:0] MSK_P2 = 8'hB2;
  localparam logic [7:0] MSK_STAT_WR = 8'hE7;
  localparam logic [1:0] FUSE_HI_PAD = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int WDT_PERIOD_MS = 18;
  localparam int WDT_CYCLES = WDT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int PSC_W = 7;
  localparam logic [12:0] ISR_VECTOR = 13'h0004;
endpackage : swwd_pkg

// ### swwd_top.sv
// power-down control and watchdog supervisor
//
// Operation
// - sleep instruction enters power-down unless interrupt pending
// - entry clears watchdog, clears powerdown, sets expiry
// - clocks, timer, converter and pins keep running
// - analog enables untouched by power-down
// - non-watchdog resets act same while asleep
// - wake on reset pin, power-on, watchdog, interrupts
// - pin/power-on reset; watchdog/interrupt continue
// - wake sources: async timer1, converter, pin-change, pin
// - next instruction prefetched during sleep instruction
// - interrupt wakes only if enabled; global ignored
// - after wake, run next then vector if global
// - watchdog cleared on every wake
// - pending enabled interrupt makes sleep a no-op
// - interrupt during sleep: complete, then wake at once
// - fuse bit enables watchdog; clear holds it cleared
// - expiry resets when awake, wakes when asleep
// - nominal 18 ms period, prescaler up to 1:128
// - clear and sleep instructions clear counter, and prescaler when assigned by PSA
// - expiry clears the expiry flag
// - prescaler ownership changeable by software any time
// - flags set regardless of enables
`timescale 1ns/100ps
`default_nettype none
module swwd_top
  import swwd_pkg::*;
#(
  parameter int WDT_LEN = WDT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core instruction decode
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic [13:0] device_fuse_word,
  // pins
  input wire logic external_reset_pin,
  input wire logic ext_irq_pin,
  input wire logic [7:0] pin_change_port_a,
  input wire logic [7:0] pin_change_port_b,
  // peripheral interrupt events
  input wire logic tmr0_ovf_evt,
  input wire logic [7:0] periph_evt_1,
  input wire logic [7:0] periph_evt_2,
  input wire logic tmr1_async,
  // core control
  output logic sleeping,
  output logic device_reset,
  output logic wake_resume,
  output logic wake_to_isr,
  output logic prefetch_next,
  output logic [12:0] isr_vector,
  output logic powerdown_flag_n,
  output logic watchdog_expiry_flag_n
);
  localparam int CNT_W = $clog2(WDT_LEN + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] irq_ctl;
    logic [7:0] ioc_a;
    logic [7:0] ioc_b;
    logic [7:0] periph_irq_enable_1;
    logic [7:0] periph_irq_enable_2;
    logic [7:0] periph_irq_flags_1;
    logic [7:0] periph_irq_flags_2;
    logic [7:0] stat;
    logic [7:0] opt;
    logic [7:0] rdata;
    logic [CNT_W-1:0] base_cnt;
    logic [PSC_W-1:0] psc;
    logic sleeping;
    logic dev_rst;
    logic wake;
    logic isr;
    logic prefetch;
    logic [2:0] int_sh;
    logic [1:0] xr_sh;
    logic [7:0] pa1;
    logic [7:0] pa2;
    logic [7:0] pa3;
    logic [7:0] pb1;
    logic [7:0] pb2;
    logic [7:0] pb3;
  } swwd_state_s;

  swwd_state_s q;
  swwd_state_s d;
  logic [1:0] rst_ff;
  logic rst_n_s;
  logic xrst;
  logic int_edge;
  logic ioc_hit;
  logic pend;
  logic wake_src;
  logic wdt_en;
  logic sleep_go;
  logic wdt_clr;
  logic base_tick;
  logic wdt_to;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [PSC_W-1:0] psc_lim(input logic [2:0] ps);
    psc_lim = PSC_W'((8'h01 << ps) - 8'h01);
  endfunction : psc_lim

  function automatic logic irq_pend(input logic [7:0] ic, input logic [7:0] e1,
                                    input logic [7:0] e2, input logic [7:0] f1,
                                    input logic [7:0] f2);
    irq_pend = (|(ic[5:3] & ic[2:0])) | (ic[B_PERIPHERAL_IRQ_GATE] & ((|(e1 & f1)) | (|(e2 & f2))));
  endfunction : irq_pend

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n_s = rst_ff[1];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // reset pin acts whether asleep or not
    xrst = ~q.xr_sh[1] & device_fuse_word[B_MCLRE];
    int_edge = q.opt[B_INTEDG] ? (q.int_sh[1] & ~q.int_sh[2]) : (~q.int_sh[1] & q.int_sh[2]);
    ioc_hit = (|((q.pa2 ^ q.pa3) & q.ioc_a)) | (|((q.pb2 ^ q.pb3) & q.ioc_b));
    pend = irq_pend(q.irq_ctl, q.periph_irq_enable_1, q.periph_irq_enable_2, q.periph_irq_flags_1, q.periph_irq_flags_2);
    // individual enables gate wake, global does not
    wake_src = (q.irq_ctl[B_INTE] & q.irq_ctl[B_INTF])
             | (q.irq_ctl[B_IOCE] & q.irq_ctl[B_IOCF])
             | (q.irq_ctl[B_PERIPHERAL_IRQ_GATE] & ((q.periph_irq_enable_1[B_ADC] & q.periph_irq_flags_1[B_ADC])
             | (tmr1_async & q.periph_irq_enable_1[B_TMR1] & q.periph_irq_flags_1[B_TMR1])));
    wdt_en = device_fuse_word[B_WATCHDOG_CFG_ENABLE];
    // pending enabled interrupt turns sleep into a no-op
    sleep_go = sleep_instr & ~q.sleeping & ~pend;
    // clear instruction and sleep entry clear the watchdog
    wdt_clr = watchdog_clear_instr | sleep_go | xrst | ~wdt_en;
    base_tick = q.base_cnt == CNT_W'(WDT_LEN - 1);
    // prescaler ratio chosen by power-of-two field
    wdt_to = ~wdt_clr & base_tick & (~q.opt[B_PSA] | (q.psc == psc_lim(q.opt[2:0])));

    // pin synchronisers
    d.int_sh = {q.int_sh[1:0], ext_irq_pin};
    d.xr_sh = {q.xr_sh[0], external_reset_pin};
    d.pa1 = pin_change_port_a;
    d.pa2 = q.pa1;
    d.pa3 = q.pa2;
    d.pb1 = pin_change_port_b;
    d.pb2 = q.pb1;
    d.pb3 = q.pb2;

    d.dev_rst = xrst;
    d.wake = 1'b0;
    d.isr = 1'b0;
    d.prefetch = 1'b0;
    d.rdata = RST_ZERO;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        A_IRQ_CTL: d.irq_ctl = reg_wdata;
        A_IOC_A: d.ioc_a = reg_wdata;
        A_IOC_B: d.ioc_b = reg_wdata & MSK_PIN_CHANGE_ENABLE_PORT_B;
        A_PERIPH_IRQ_ENABLE_1: d.periph_irq_enable_1 = reg_wdata & MSK_P1;
        A_PERIPH_IRQ_ENABLE_2: d.periph_irq_enable_2 = reg_wdata & MSK_P2;
        A_PERIPH_IRQ_FLAGS_1: d.periph_irq_flags_1 = reg_wdata & MSK_P1;
        A_PERIPH_IRQ_FLAGS_2: d.periph_irq_flags_2 = reg_wdata & MSK_P2;
        // flag bits of status stay hardware-owned
        A_STATUS: d.stat = (reg_wdata & MSK_STAT_WR) | (q.stat & ~MSK_STAT_WR);
        // ownership bit may change at any time
        A_OPTION: d.opt = reg_wdata;
        default: d.opt = d.opt;
      endcase
    end

    // register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        A_IRQ_CTL: d.rdata = q.irq_ctl;
        A_IOC_A: d.rdata = q.ioc_a;
        A_IOC_B: d.rdata = q.ioc_b;
        A_PERIPH_IRQ_ENABLE_1: d.rdata = q.periph_irq_enable_1;
        A_PERIPH_IRQ_ENABLE_2: d.rdata = q.periph_irq_enable_2;
        A_PERIPH_IRQ_FLAGS_1: d.rdata = q.periph_irq_flags_1;
        A_PERIPH_IRQ_FLAGS_2: d.rdata = q.periph_irq_flags_2;
        A_STATUS: d.rdata = q.stat;
        A_OPTION: d.rdata = q.opt;
        A_FUSE_LO: d.rdata = device_fuse_word[7:0];
        A_FUSE_HI: d.rdata = {FUSE_HI_PAD, device_fuse_word[13:8]};
        default: d.rdata = RST_ZERO;
      endcase
    end

    // flags set regardless of enables; set beats clear
    d.irq_ctl[B_T0IF] = d.irq_ctl[B_T0IF] | tmr0_ovf_evt;
    d.irq_ctl[B_INTF] = d.irq_ctl[B_INTF] | int_edge;
    d.irq_ctl[B_IOCF] = d.irq_ctl[B_IOCF] | ioc_hit;
    d.periph_irq_flags_1 = (d.periph_irq_flags_1 | periph_evt_1) & MSK_P1;
    d.periph_irq_flags_2 = (d.periph_irq_flags_2 | periph_evt_2) & MSK_P2;

    if (wdt_clr) begin
      d.base_cnt = '0;
      if (q.opt[B_PSA] | ~wdt_en) begin
        d.psc = '0;
      end
    end else if (base_tick) begin
      d.base_cnt = '0;
      if (q.opt[B_PSA]) begin
        d.psc = wdt_to ? '0 : q.psc + 1'b1;
      end
    end else begin
      d.base_cnt = q.base_cnt + 1'b1;
    end

    if (wdt_to) begin
      d.stat[B_TO] = 1'b0;
      // awake expiry is a device reset
      if (!q.sleeping) begin
        d.dev_rst = 1'b1;
      end
    end

    // reset pin resets; other wakes resume execution
    if (xrst) begin
      d.sleeping = 1'b0;
    end else if (q.sleeping) begin
      // wake on watchdog or enabled interrupt
      if (wake_src | wdt_to) begin
        d.sleeping = 1'b0;
        d.wake = 1'b1;
        // vector only for interrupt wake with global set
        d.isr = wake_src & q.irq_ctl[B_GIE];
        d.base_cnt = '0;
        if (q.opt[B_PSA]) begin
          d.psc = '0;
        end
      end
    end else if (sleep_instr) begin
      // core fetches the following word meanwhile
      d.prefetch = 1'b1;
      // no-op keeps counters and flags untouched
      if (!pend) begin
        // entry sets flags; counters cleared above
        // a flag set now wakes on the next cycle
        // no clock or pin gating here, so all keep running
        // analog enables have no path from this logic
        d.sleeping = 1'b1;
        d.stat[B_PD] = 1'b0;
        d.stat[B_TO] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      q <= '0;
      // reset pin idles high, so its synchroniser starts high to avoid a false reset
      q.xr_sh <= 2'h3;
      q.stat <= RST_STATUS;
      q.opt <= RST_OPTION;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign sleeping = q.sleeping;
  assign device_reset = q.dev_rst;
  assign wake_resume = q.wake;
  assign wake_to_isr = q.isr;
  assign prefetch_next = q.prefetch;
  assign isr_vector = ISR_VECTOR;
  assign powerdown_flag_n = q.stat[B_PD];
  assign watchdog_expiry_flag_n = q.stat[B_TO];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_s);

  property p_entry;
    sleep_instr && !q.sleeping && !pend && !xrst |=> q.sleeping && !q.stat[B_PD] && q.stat[B_TO] && q.base_cnt == 0;
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entry wrong");

  property p_nop;
    sleep_instr && !q.sleeping && pend && !xrst |=> !q.sleeping && q.stat[B_PD] == $past(q.stat[B_PD]);
  endproperty
  a_nop: assert property (p_nop) else $error("sleep no-op changed state");

  property p_irq_wake;
    q.sleeping && wake_src && !xrst |=> !q.sleeping && q.wake && q.isr == $past(q.irq_ctl[B_GIE]) && q.base_cnt == 0;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");

  property p_clr;
    watchdog_clear_instr |=> q.base_cnt == 0 && (!$past(q.opt[B_PSA]) || q.psc == 0);
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not clear");

  property p_off;
    !wdt_en |=> q.base_cnt == 0 && q.stat[B_TO];
  endproperty
  a_off: assert property (p_off) else $error("disabled watchdog moved");

  property p_awake_to;
    wdt_to && !q.sleeping |=> q.dev_rst && !q.stat[B_TO] && !q.wake;
  endproperty
  a_awake_to: assert property (p_awake_to) else $error("awake expiry did not reset");

  property p_sleep_to;
    wdt_to && q.sleeping && !xrst |=> !q.sleeping && q.wake && !q.dev_rst && !q.stat[B_TO];
  endproperty
  a_sleep_to: assert property (p_sleep_to) else $error("asleep expiry did not wake");

  property p_ratio;
    wdt_to |-> q.base_cnt == CNT_W'(WDT_LEN - 1) && (!q.opt[B_PSA] || q.psc == psc_lim(q.opt[2:0]));
  endproperty
  a_ratio: assert property (p_ratio) else $error("expiry at wrong count");

  property p_flag;
    int_edge |=> q.irq_ctl[B_INTF];
  endproperty
  a_flag: assert property (p_flag) else $error("edge flag lost");

  property p_xrst;
    xrst |=> q.dev_rst && !q.sleeping;
  endproperty
  a_xrst: assert property (p_xrst) else $error("reset pin ignored");

  property p_prefetch;
    sleep_instr && !q.sleeping && !xrst |=> q.prefetch ##1 !q.prefetch;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch pulse wrong");
endmodule : swwd_top
`default_nettype wire

// ### swwd_core_model.sv
// core-side partner model: issues instructions and watches the power-down flag
`timescale 1ns/100ps
`default_nettype none
module swwd_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // requests from the bench
  input wire logic req_sleep,
  input wire logic req_clr,
  // status from the supervisor
  input wire logic sleeping,
  input wire logic prefetch_next,
  input wire logic powerdown_flag_n,
  // instruction decode towards the supervisor, no-op flag towards the bench
  output logic sleep_instr,
  output logic watchdog_clear_instr,
  output logic nop_seen
);
  // no-op after sleep
  // a sleeping core has a no-op in flight, so it issues nothing until woken
  assign sleep_instr = req_sleep & ~sleeping;
  assign watchdog_clear_instr = req_clr & ~sleeping;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nop_seen <= 1'b0;
    end else if (prefetch_next) begin
      nop_seen <= powerdown_flag_n;
    end
  end
endmodule : swwd_core_model
`default_nettype wire

// ### sleep_wake_watchdog_test.sv
// self-checking bench for the power-down and watchdog supervisor
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_watchdog_test;
  import swwd_pkg::*;
  localparam int WL = 20;
  localparam logic [13:0] FUSE = 14'h1F28;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic req_sleep = 1'b0;
  logic req_clr = 1'b0;
  logic sleep_instr, watchdog_clear_instr, nop_seen;
  logic [13:0] device_fuse_word = FUSE;
  logic external_reset_pin = 1'b1;
  logic ext_irq_pin = 1'b0;
  logic [7:0] pin_change_port_a = 8'h00;
  logic [7:0] pin_change_port_b = 8'h00;
  logic tmr0_ovf_evt = 1'b0;
  logic [7:0] periph_evt_1 = 8'h00;
  logic [7:0] periph_evt_2 = 8'h00;
  logic tmr1_async = 1'b0;
  logic sleeping, device_reset, wake_resume, wake_to_isr, prefetch_next;
  logic [12:0] isr_vector;
  logic powerdown_flag_n, watchdog_expiry_flag_n;
  int err_total = 0;
  int checks_done = 0;
  int rst_seen = 0;
  int n, r0;
  logic [7:0] d;
  // ---------------------------------------------------------------
  // clock, instances
  // ---------------------------------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  swwd_top #(.WDT_LEN(WL)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .device_fuse_word(device_fuse_word),
    .external_reset_pin(external_reset_pin), .ext_irq_pin(ext_irq_pin), .pin_change_port_a(pin_change_port_a),
    .pin_change_port_b(pin_change_port_b), .tmr0_ovf_evt(tmr0_ovf_evt), .periph_evt_1(periph_evt_1),
    .periph_evt_2(periph_evt_2), .tmr1_async(tmr1_async), .sleeping(sleeping), .device_reset(device_reset),
    .wake_resume(wake_resume), .wake_to_isr(wake_to_isr), .prefetch_next(prefetch_next), .isr_vector(isr_vector),
    .powerdown_flag_n(powerdown_flag_n), .watchdog_expiry_flag_n(watchdog_expiry_flag_n));
  swwd_core_model core_u (.ref_clk(ref_clk), .rstn(rstn), .req_sleep(req_sleep), .req_clr(req_clr),
    .sleeping(sleeping), .prefetch_next(prefetch_next), .powerdown_flag_n(powerdown_flag_n),
    .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr), .nop_seen(nop_seen));
  always @(negedge ref_clk) begin
    if (device_reset === 1'b1) rst_seen++;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask : rd
  task automatic instr(input bit slp);
    @(posedge ref_clk);
    if (slp) req_sleep <= 1'b1;
    else req_clr <= 1'b1;
    @(posedge ref_clk);
    req_sleep <= 1'b0;
    req_clr <= 1'b0;
    @(negedge ref_clk);
  endtask : instr
  // waits for a wake pulse (which 0) or a reset pulse (which 1), n is the cycle count
  task automatic wait_hi(input bit which, input int lim, output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (k < lim && ((which ? device_reset : wake_resume) !== 1'b1));
  endtask : wait_hi
  task automatic do_reset();
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(3);
  endtask : do_reset
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd(A_STATUS, d); chk("status", d, 8'h18);
    wr(A_STATUS, 8'h00);
    rd(A_STATUS, d); chk("status ro", d, 8'h18);
    rd(A_OPTION, d); chk("option", d, 8'hFF);
    rd(A_FUSE_LO, d); chk("fuse lo", d, 8'h28);
    rd(A_FUSE_HI, d); chk("fuse hi", d, 8'hDF);
    rd(4'hB, d); chk("unmapped", d, 8'h00);
    chk("vector", isr_vector, 13'h0004);
  endtask : t_regs
  task automatic t_nop();
    instr(0);
    wr(A_IRQ_CTL, 8'h12);
    instr(1);
    chk("nop prefetch", prefetch_next, 1'b1);
    chk("nop sleeping", sleeping, 1'b0);
    chk("nop pd", powerdown_flag_n, 1'b1);
    chk("nop to", watchdog_expiry_flag_n, 1'b1);
    cyc(1);
    @(negedge ref_clk);
    chk("nop seen", nop_seen, 1'b1);
    wr(A_IRQ_CTL, 8'h00);
  endtask : t_nop
  task automatic t_irq_wake();
    wr(A_IRQ_CTL, 8'h90);
    instr(1);
    chk("sleep", sleeping, 1'b1);
    chk("sleep pd", powerdown_flag_n, 1'b0);
    chk("sleep to", watchdog_expiry_flag_n, 1'b1);
    chk("prefetch", prefetch_next, 1'b1);
    @(posedge ref_clk);
    ext_irq_pin <= 1'b1;
    wait_hi(0, 10, n);
    chk("irq wake", wake_resume, 1'b1);
    chk("to isr", wake_to_isr, 1'b1);
    @(negedge ref_clk);
    chk("awake", sleeping, 1'b0);
    wr(A_IRQ_CTL, 8'h00);
    ext_irq_pin <= 1'b0;
  endtask : t_irq_wake
  task automatic t_periph_wake();
    instr(0);
    wr(A_IOC_A, 8'h01);
    wr(A_PERIPH_IRQ_ENABLE_1, 8'h41);
    wr(A_IRQ_CTL, 8'h48);
    instr(1);
    @(posedge ref_clk);
    periph_evt_1 <= 8'h01;
    @(posedge ref_clk);
    periph_evt_1 <= 8'h00;
    cyc(4);
    chk("sync tmr1 no wake", sleeping, 1'b1);
    wr(A_IRQ_CTL, 8'h08);
    rd(A_PERIPH_IRQ_FLAGS_1, d); chk("flag set", d, 8'h01);
    wr(A_PERIPH_IRQ_FLAGS_1, 8'h00);
    @(posedge ref_clk);
    pin_change_port_a <= 8'h01;
    wait_hi(0, 12, n);
    chk("ioc wake", wake_resume, 1'b1);
    chk("in line", wake_to_isr, 1'b0);
    wr(A_IRQ_CTL, 8'h00);
    wr(A_PERIPH_IRQ_ENABLE_1, 8'h00);
  endtask : t_periph_wake
  task automatic t_wdt();
    wr(A_OPTION, 8'hF0);
    instr(0);
    wait_hi(1, 100, n);
    chk("period 1:1", (n >= WL - 1 && n <= WL + 2), 1'b1);
    chk("expiry flag", watchdog_expiry_flag_n, 1'b0);
    wr(A_OPTION, 8'hF9);
    instr(0);
    wait_hi(1, 200, n);
    chk("period 1:2", (n >= 2 * WL - 2 && n <= 2 * WL + 3), 1'b1);
    wr(A_OPTION, 8'hF0);
    r0 = rst_seen;
    repeat (6) begin
      instr(0);
      cyc(WL / 2);
    end
    chk("clear holds", rst_seen - r0, 16'h0);
    instr(1);
    wait_hi(0, 100, n);
    chk("wdt wake", (n >= WL - 2 && n <= WL + 2), 1'b1);
    chk("wake no reset", rst_seen - r0, 16'h0);
    chk("wake flag", watchdog_expiry_flag_n, 1'b0);
    wait_hi(1, 100, n);
    chk("cleared on wake", (n >= WL - 2 && n <= WL + 2), 1'b1);
    wr(A_OPTION, 8'hFF);
  endtask : t_wdt
  task automatic t_fuse_pin();
    device_fuse_word <= FUSE & 14'h3FF7;
    do_reset();
    r0 = rst_seen;
    cyc(3 * WL);
    chk("wdt off", rst_seen - r0, 16'h0);
    chk("wdt off flag", watchdog_expiry_flag_n, 1'b1);
    instr(1);
    @(posedge ref_clk);
    external_reset_pin <= 1'b0;
    cyc(4);
    @(negedge ref_clk);
    chk("pin reset", device_reset, 1'b1);
    chk("pin wake", sleeping, 1'b0);
    @(posedge ref_clk);
    external_reset_pin <= 1'b1;
    cyc(5);
    @(negedge ref_clk);
    chk("pin release", device_reset, 1'b0);
  endtask : t_fuse_pin
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    t_regs();
    t_nop();
    t_irq_wake();
    t_periph_wake();
    t_wdt();
    t_fuse_pin();
    conclude();
  end
  initial begin
    #100us;
    err_total++;
    conclude();
  end
endmodule : sleep_wake_watchdog_test
`default_nettype wire
